// ---- sc_sysctl.sv ----
/*
 * sc_sysctl: system control interface top - oscillator enables, retained
 * registers, generic clocks and interrupt status over an APB slave.
 * Assumes APB inputs and status flags synchronous to clk_sys_i.
 */
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sc_sysctl
    import sc_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic              por_rstn_i,
    input  wire sc_apb_req_t       apb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic [31:0]       pwr_clk_flags_i,
    input  wire logic              sm_sampling_req_i,
    input  wire logic              slow_rc_clk_i,
    input  wire logic              pm_slow_out_en_i,
    input  wire logic              pin_func_default_i,
    input  wire logic              sleep_pb_off_i,
    input  wire logic [SRC_N-1:0]  gclk_src_i,
    output logic                   fast_rc_osc_en_o,
    output logic                   slow_rc_osc_en_o,
    output logic                   slow_rc_osc_run_o,
    output logic                   slow_osc_out_pin_o,
    output logic [GCLK_N-1:0]      gclk_o,
    output logic                   irq_o
);
    logic        setup, access, wr_acc, hit;
    logic        sel_ier, sel_idr, sel_icr, sel_unlock;
    logic        sel_fast, sel_slow, sel_br, sel_gc;
    logic [2:0]  gc_idx;
    logic [1:0]  br_idx;
    logic        prot, prot_ok;
    logic [31:0] rd_d, prdata_q;
    logic        rd_br_q;
    logic        unlock_arm_q;
    logic [AW-1:0] unlock_ofs_q;
    logic        ae_evt;
    logic        fast_en_q, slow_en_q;
    logic [31:0] imr_q, isr_q, isr_d;
    logic [31:0] stat, stat_q, stat_rise;
    logic        irq_q;
    logic        pin_q;
    logic [31:0] gc_q [GCLK_N];
    logic [GCLK_N-1:0] gc_run;
    logic        br_wr, br_ready, br_valid;
    logic [31:0] br_rdata;

    // bus phases and address decode
    assign setup  = apb_i.psel & ~apb_i.penable;
    assign access = apb_i.psel & apb_i.penable;
    assign wr_acc = access & apb_i.pwrite;

    assign sel_ier    = apb_i.paddr == OFS_IRQ_ENABLE_SET;
    assign sel_idr    = apb_i.paddr == OFS_IRQ_DISABLE_SET;
    assign sel_icr    = apb_i.paddr == OFS_IRQ_CLEAR;
    assign sel_unlock = apb_i.paddr == OFS_UNLOCK;
    assign sel_fast   = apb_i.paddr == OFS_FAST_OSC_CFG;
    assign sel_slow   = apb_i.paddr == OFS_SLOW_OSC_CFG;
    assign sel_br     = apb_i.paddr[1:0] == 2'h0
                        && apb_i.paddr >= OFS_RETAINED_BASE
                        && apb_i.paddr < OFS_SLOW_OSC_CFG;
    assign sel_gc     = apb_i.paddr[1:0] == 2'h0
                        && apb_i.paddr >= OFS_GEN_CLK_BASE
                        && apb_i.paddr < OFS_GEN_CLK_BASE + 12'h014;
    assign br_idx     = 2'((apb_i.paddr - OFS_RETAINED_BASE) >> 2);
    assign gc_idx     = 3'((apb_i.paddr - OFS_GEN_CLK_BASE) >> 2);

    assign hit = sel_ier | sel_idr | sel_icr | sel_unlock | sel_fast
               | sel_slow | sel_br | sel_gc
               | apb_i.paddr == OFS_IRQ_MASK
               | apb_i.paddr == OFS_IRQ_STATUS
               | apb_i.paddr == OFS_PWR_CLK_STATUS;

    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~hit;

    // protected oscillator registers need an armed unlock
    assign prot    = sel_fast | sel_slow;
    assign prot_ok = unlock_arm_q && unlock_ofs_q == apb_i.paddr;
    assign ae_evt  = wr_acc & prot & ~prot_ok;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            unlock_arm_q <= 1'b0;
            unlock_ofs_q <= '0;
        end else if (wr_acc) begin
            unlock_arm_q <= sel_unlock
                && apb_i.pwdata[UNLOCK_KEY_LSB +: 8] == UNLOCK_KEY;
            unlock_ofs_q <= apb_i.pwdata[AW-1:0];
        end
    end

    // oscillator controls
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            fast_en_q <= 1'b0;
        end else if (wr_acc && sel_fast && prot_ok) begin
            fast_en_q <= apb_i.pwdata[OSC_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            slow_en_q <= 1'b0;
        end else if (wr_acc && sel_slow && prot_ok) begin
            slow_en_q <= apb_i.pwdata[OSC_EN_BIT];
        end
    end

    assign fast_rc_osc_en_o  = fast_en_q;
    assign slow_rc_osc_en_o  = slow_en_q | sm_sampling_req_i;
    assign slow_rc_osc_run_o = slow_rc_osc_en_o | (pm_slow_out_en_i & pin_func_default_i);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= slow_rc_clk_i & pm_slow_out_en_i & pin_func_default_i;
        end
    end
    assign slow_osc_out_pin_o = pin_q;

    // retained registers
    assign br_wr = wr_acc & sel_br;

    sc_retain_mem u_retain (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .por_rstn_i(por_rstn_i),
        .wr_i      (br_wr),
        .wr_idx_i  (br_idx),
        .wr_data_i (apb_i.pwdata),
        .rd_idx_i  (br_idx),
        .rd_data_o (br_rdata),
        .ready_o   (br_ready),
        .valid_o   (br_valid)
    );

    // generic clock channels
    genvar g;
    generate
        for (g = 0; g < GCLK_N; g++) begin : g_gclk
            always_ff @(posedge clk_sys_i) begin
                if (!rstn_i) begin
                    gc_q[g] <= '0;
                end else if (wr_acc && sel_gc && gc_idx == 3'(g)) begin
                    gc_q[g] <= apb_i.pwdata & GC_RW_MASK;
                end
            end

            sc_gclk_gen u_gen (
                .clk_sys_i(clk_sys_i),
                .rstn_i   (rstn_i),
                .src_i    (gclk_src_i[gc_q[g][GC_SEL_LSB +: GC_SEL_W]]),
                .cen_i    (gc_q[g][GC_CEN_BIT] & ~sleep_pb_off_i),
                .div_on_i (gc_q[g][GC_DIV_BIT]),
                .div_i    (gc_q[g][GC_DIVF_LSB +: GC_DIVF_W]),
                .gclk_o   (gclk_o[g]),
                .running_o(gc_run[g])
            );
        end
    endgenerate

    // status flags and interrupt sources
    always_comb begin
        stat = pwr_clk_flags_i & EXT_FLAG_MASK;
        stat[BIT_RETAIN_READY] = br_ready;
        stat[BIT_RETAIN_VALID] = br_valid;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            stat_q <= STATUS_RST;
        end else begin
            stat_q <= stat;
        end
    end

    always_comb begin
        stat_rise = stat & ~stat_q & IRQ_SRC_MASK;
        stat_rise[BIT_ACCESS_ERROR] = ae_evt;
        isr_d = isr_q;
        if (wr_acc && sel_icr) begin
            isr_d = isr_q & ~apb_i.pwdata;
        end
        isr_d = isr_d | stat_rise;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            isr_q <= '0;
        end else begin
            isr_q <= isr_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            imr_q <= '0;
        end else if (wr_acc && sel_ier) begin
            imr_q <= imr_q | (apb_i.pwdata & IRQ_SRC_MASK);
        end else if (wr_acc && sel_idr) begin
            imr_q <= imr_q & ~apb_i.pwdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(isr_d & imr_q);
        end
    end
    assign irq_o = irq_q;

    // read data captured in the setup cycle
    always_comb begin
        rd_d = '0;
        unique case (1'b1)
            apb_i.paddr == OFS_IRQ_MASK:       rd_d = imr_q;
            apb_i.paddr == OFS_IRQ_STATUS:     rd_d = isr_q;
            apb_i.paddr == OFS_PWR_CLK_STATUS: rd_d = stat;
            sel_fast: rd_d[OSC_EN_BIT] = fast_en_q;
            sel_slow: rd_d[OSC_EN_BIT] = slow_en_q;
            sel_gc: begin
                rd_d = gc_q[gc_idx];
                rd_d[GC_CEN_BIT] = gc_q[gc_idx][GC_CEN_BIT] | gc_run[gc_idx];
            end
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            prdata_q <= '0;
            rd_br_q  <= 1'b0;
        end else if (setup) begin
            prdata_q <= rd_d;
            rd_br_q  <= sel_br;
        end
    end

    assign prdata_o = rd_br_q ? br_rdata : prdata_q;

    a_fast_osc_follow: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        wr_acc && sel_fast && prot_ok |=> fast_rc_osc_en_o == $past(apb_i.pwdata[OSC_EN_BIT]))
        else $error("fast oscillator enable not taken");
    a_slow_osc_held: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        sm_sampling_req_i |-> slow_rc_osc_en_o)
        else $error("slow oscillator off while sampling");
    a_retain_rise_irq: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(br_ready) |=> isr_q[BIT_RETAIN_READY])
        else $error("ready edge not flagged");
    a_access_err_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ae_evt |=> isr_q[BIT_ACCESS_ERROR])
        else $error("access error not flagged");
    a_isr_sticky: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        isr_q[5'd16] && !(wr_acc && sel_icr && apb_i.pwdata[16]) |=> isr_q[5'd16])
        else $error("status bit lost without clear");
    a_irq_masked_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (imr_q == '0) ##1 (imr_q == '0) |-> !irq_o)
        else $error("request with all sources masked");
    a_mask_zero_keep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        wr_acc && (sel_ier || sel_idr) |=> (imr_q & ~$past(apb_i.pwdata))
            == ($past(imr_q) & ~$past(apb_i.pwdata)))
        else $error("mask changed by zero bit");
    a_gc_cen_reads: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        setup && sel_gc && gc_run[gc_idx] |=> prdata_q[0])
        else $error("enable read low while running");
endmodule : sc_sysctl
`default_nettype wire

// ---- sc_pkg.sv ----
/*
 * sc_pkg: constants, offsets, field layouts and carrier types of the
 * system control interface. Assumes a 40 MHz bus clock.
 */
package sc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int BR_WRITE_NS   = 100;
    localparam int BR_WRITE_CYC  = (BR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int AW     = 12;
    localparam int BR_N   = 4;
    localparam int GCLK_N = 5;
    localparam int SRC_N  = 8;

    localparam logic [AW-1:0] OFS_IRQ_ENABLE_SET  = 12'h000;
    localparam logic [AW-1:0] OFS_IRQ_DISABLE_SET = 12'h004;
    localparam logic [AW-1:0] OFS_IRQ_MASK        = 12'h008;
    localparam logic [AW-1:0] OFS_IRQ_STATUS      = 12'h00C;
    localparam logic [AW-1:0] OFS_IRQ_CLEAR       = 12'h010;
    localparam logic [AW-1:0] OFS_PWR_CLK_STATUS  = 12'h014;
    localparam logic [AW-1:0] OFS_UNLOCK          = 12'h018;
    localparam logic [AW-1:0] OFS_FAST_OSC_CFG    = 12'h058;
    localparam logic [AW-1:0] OFS_RETAINED_BASE   = 12'h05C;
    localparam logic [AW-1:0] OFS_SLOW_OSC_CFG    = 12'h06C;
    localparam logic [AW-1:0] OFS_GEN_CLK_BASE    = 12'h070;

    localparam int BIT_ACCESS_ERROR = 31;
    localparam int BIT_RETAIN_VALID = 17;
    localparam int BIT_RETAIN_READY = 16;
    localparam logic [31:0] IRQ_SRC_MASK   = 32'h8001FF1F;
    localparam logic [31:0] EXT_FLAG_MASK  = 32'h0000FF1F;
    localparam logic [31:0] STATUS_RST     = 32'h00010000;

    localparam logic [7:0] UNLOCK_KEY = 8'hAA;
    localparam int UNLOCK_KEY_LSB = 24;

    localparam int OSC_EN_BIT  = 0;
    localparam int GC_CEN_BIT  = 0;
    localparam int GC_DIV_BIT  = 1;
    localparam int GC_SEL_LSB  = 8;
    localparam int GC_SEL_W    = 3;
    localparam int GC_DIVF_LSB = 16;
    localparam int GC_DIVF_W   = 8;
    localparam logic [31:0] GC_RW_MASK = 32'h00FF0703;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } sc_apb_req_t;
endpackage : sc_pkg

// ---- sc_gclk_gen.sv ----
/*
 * sc_gclk_gen: one generic clock channel, even divider and glitch-free gate.
 * Assumes the selected source is a level sampled on the bus clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sc_gclk_gen
    import sc_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    input  wire logic                 src_i,
    input  wire logic                 cen_i,
    input  wire logic                 div_on_i,
    input  wire logic [GC_DIVF_W-1:0] div_i,
    output logic                      gclk_o,
    output logic                      running_o
);
    logic                 src_q, raw_q, en_q, out_q;
    logic                 raw_d, en_d, src_rise, fall;
    logic [GC_DIVF_W-1:0] cnt_q;

    assign src_rise = src_i & ~src_q;

    always_comb begin
        raw_d = src_i;
        if (div_on_i) begin
            raw_d = (src_rise && cnt_q == div_i) ? ~raw_q : raw_q;
        end
        fall = raw_q & ~raw_d;
        en_d = fall ? cen_i : en_q;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            src_q <= 1'b0;
            raw_q <= 1'b0;
        end else begin
            src_q <= src_i;
            raw_q <= raw_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || !div_on_i) begin
            cnt_q <= '0;
        end else if (src_rise) begin
            cnt_q <= (cnt_q == div_i) ? '0 : cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            en_q  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            en_q  <= en_d;
            out_q <= raw_d & en_d;
        end
    end

    assign gclk_o    = out_q;
    assign running_o = en_q;

    a_gclk_no_runt: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $changed(en_q) |-> !out_q) else $error("gate moved while clock high");
    a_gclk_gate_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !en_q |=> !out_q) else $error("clock output while gated");
endmodule : sc_gclk_gen
`default_nettype wire

// ---- sc_retain_mem.sv ----
/*
 * sc_retain_mem: four retained words with ready and valid tracking.
 * Assumes por_rstn_i only at power-up; rstn_i is the system reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sc_retain_mem
    import sc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        por_rstn_i,
    input  wire logic        wr_i,
    input  wire logic [1:0]  wr_idx_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic [1:0]  rd_idx_i,
    output logic [31:0]      rd_data_o,
    output logic             ready_o,
    output logic             valid_o
);
    logic [31:0] mem_q [BR_N];
    logic [2:0]  busy_q;
    logic        valid_q, take;

    assign take = wr_i & ready_o;

    always_ff @(posedge clk_sys_i) begin
        if (!por_rstn_i) begin
            for (int i = 0; i < BR_N; i++) begin
                mem_q[i] <= '0;
            end
        end else if (take) begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        rd_data_o <= mem_q[rd_idx_i];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!por_rstn_i) begin
            busy_q  <= '0;
            valid_q <= 1'b0;
        end else if (!rstn_i) begin
            if (busy_q != '0) begin
                valid_q <= 1'b0;
            end
            busy_q <= '0;
        end else if (take) begin
            busy_q  <= 3'(BR_WRITE_CYC);
            valid_q <= 1'b1;
        end else if (busy_q != '0) begin
            busy_q <= busy_q - 1'b1;
        end
    end

    assign ready_o = (busy_q == '0);
    assign valid_o = valid_q & ready_o;

    sequence s_busy_window;
        !ready_o [*4] ##1 ready_o;
    endsequence
    a_br_busy_time: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i || !por_rstn_i)
        take |=> s_busy_window) else $error("ready window not four cycles");
    a_br_valid_low: assert property (@(posedge clk_sys_i) disable iff (!por_rstn_i)
        !rstn_i && busy_q != '0 |=> !valid_q) else $error("valid kept after busy reset");
    a_br_valid_set: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i || !por_rstn_i)
        take |-> ##5 valid_o) else $error("valid not set after write");
endmodule : sc_retain_mem
`default_nettype wire

// ---- sc_apb_host.sv ----
/*
 * sc_apb_host: software side of the register bus, issues APB transfers.
 * Assumes a caller in the same clock domain and a slave that answers with pready.
 */
`timescale 1ns/1ps
`default_nettype none
module sc_apb_host
    import sc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output var sc_apb_req_t  apb_o
);
    initial apb_o = '0;

    // setup, then access held until pready; data and error taken at that edge
    task automatic xfer(input logic wr, input logic [AW-1:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk_sys_i);
        apb_o <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge clk_sys_i);
        apb_o.penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready_i !== 1'b1);
        rdata = prdata_i;
        err   = pslverr_i;
        apb_o <= '0;
    endtask : xfer
endmodule : sc_apb_host
`default_nettype wire

// ---- tb_top.sv ----
/*
 * tb_top: self-checking bench of the system control interface.
 * Assumes sc_pkg, sc_apb_host and a 40 MHz bus clock; no random stimulus.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sc_pkg::*;
;
    logic              clk_sys_i, rstn_i, por_rstn_i, pready_o, pslverr_o, err_q, irq_o;
    sc_apb_req_t       apb_i;
    logic [31:0]       prdata_o, pwr_clk_flags_i, rd_q;
    logic              sm_sampling_req_i, slow_rc_clk_i, pm_slow_out_en_i;
    logic              pin_func_default_i, sleep_pb_off_i, fast_rc_osc_en_o;
    logic              slow_rc_osc_en_o, slow_rc_osc_run_o, slow_osc_out_pin_o;
    logic [SRC_N-1:0]  gclk_src_i;
    logic [GCLK_N-1:0] gclk_o;
    logic [1:0]        src_cnt;
    int                err_count, n_tests, cyc_cnt;

    sc_sysctl uut (.clk_sys_i, .rstn_i, .por_rstn_i, .apb_i, .prdata_o, .pready_o, .pslverr_o,
        .pwr_clk_flags_i, .sm_sampling_req_i, .slow_rc_clk_i, .pm_slow_out_en_i,
        .pin_func_default_i, .sleep_pb_off_i, .gclk_src_i, .fast_rc_osc_en_o,
        .slow_rc_osc_en_o, .slow_rc_osc_run_o, .slow_osc_out_pin_o, .gclk_o, .irq_o);
    sc_apb_host host (.clk_sys_i, .pready_i(pready_o), .pslverr_i(pslverr_o),
        .prdata_i(prdata_o), .apb_o(apb_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // source 0 toggles every cycle, source 1 every two; hang guard
    always @(posedge clk_sys_i) begin
        src_cnt    <= src_cnt + 2'h1;
        gclk_src_i <= {6'h00, src_cnt};
        cyc_cnt    <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd_q, err_q);
    endtask : wr
    task automatic rd(input logic [AW-1:0] a);
        host.xfer(1'b0, a, 32'h0, rd_q, err_q);
    endtask : rd
    task automatic pwr(input logic [AW-1:0] a, input logic [31:0] d);
        wr(OFS_UNLOCK, {UNLOCK_KEY, 12'h000, a});
        wr(a, d);
    endtask : pwr
    task automatic wait_rdy();
        for (int i = 0; i < 20; i++) begin
            rd(OFS_PWR_CLK_STATUS);
            if (rd_q[BIT_RETAIN_READY] === 1'b1) break;
        end
    endtask : wait_rdy
    task automatic rst_pulse();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
    endtask : rst_pulse
    task automatic period(input int ch, output int p);
        logic pv;
        int   t0;
        pv = gclk_o[ch];
        t0 = -1;
        p  = 0;
        for (int t = 0; t < 2600 && p == 0; t++) begin
            cyc(1);
            if (pv === 1'b0 && gclk_o[ch] === 1'b1) begin
                if (t0 >= 0) p = t - t0;
                t0 = t;
            end
            pv = gclk_o[ch];
        end
    endtask : period
    function automatic logic [31:0] gc(input logic [2:0] s, input logic [7:0] dv,
                                       input logic dven, input logic on);
        return {8'h00, dv, 5'h00, s, 6'h00, dven, on};
    endfunction : gc

    task automatic t_reset();
        cyc(1);
        chk("fast_en", fast_rc_osc_en_o, 1'b0);
        chk("slow_run", slow_rc_osc_run_o, 1'b1);
        chk("slow_en", slow_rc_osc_en_o, 1'b0);
        rd(OFS_IRQ_MASK);
        chk("mask", rd_q, 32'h0);
        rd(OFS_IRQ_STATUS);
        chk("status", rd_q, 32'h0);
        rd(OFS_PWR_CLK_STATUS);
        chk("rdy_valid", rd_q[17:16], 2'b01);
        rd(12'h0FC);
        chk("unmapped", {err_q, rd_q[30:0]}, 32'h80000000);
    endtask : t_reset

    task automatic t_fast();
        wr(OFS_FAST_OSC_CFG, 32'h1);
        cyc(1);
        chk("fast_locked", fast_rc_osc_en_o, 1'b0);
        rd(OFS_IRQ_STATUS);
        chk("access_err", rd_q, 32'h80000000);
        wr(OFS_IRQ_CLEAR, 32'h80000000);
        rd(OFS_IRQ_STATUS);
        chk("ae_clear", rd_q, 32'h0);
        pwr(OFS_FAST_OSC_CFG, 32'h1);
        cyc(1);
        chk("fast_on", fast_rc_osc_en_o, 1'b1);
        pwr(OFS_FAST_OSC_CFG, 32'h0);
        cyc(1);
        chk("fast_off", fast_rc_osc_en_o, 1'b0);
    endtask : t_fast

    task automatic t_retain();
        logic [31:0] ew [4];
        ew = '{32'hA5A50001, 32'h5A5A0002, 32'h0, 32'hFFFFFFFF};
        wr(OFS_RETAINED_BASE, ew[0]);
        rd(OFS_PWR_CLK_STATUS);
        chk("busy_flags", rd_q[17:16], 2'b00);
        wait_rdy();
        wr(OFS_RETAINED_BASE + 12'h4, ew[1]);
        wr(OFS_RETAINED_BASE + 12'h8, 32'h0000BEEF);
        wait_rdy();
        wr(OFS_RETAINED_BASE + 12'hC, ew[3]);
        wait_rdy();
        chk("valid_set", rd_q[17:16], 2'b11);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_RETAINED_BASE + 12'(4 * i));
            chk("retained", rd_q, ew[i]);
        end
        rd(OFS_IRQ_STATUS);
        chk("ready_event", rd_q, 32'h00010000);
        rst_pulse();
        rd(OFS_PWR_CLK_STATUS);
        chk("valid_kept", rd_q[17:16], 2'b11);
        rd(OFS_RETAINED_BASE + 12'h4);
        chk("word_kept", rd_q, ew[1]);
        wr(OFS_RETAINED_BASE, 32'h12345678);
        rst_pulse();
        wait_rdy();
        chk("valid_lost", rd_q[17], 1'b0);
    endtask : t_retain

    task automatic t_slow();
        @(posedge clk_sys_i);
        slow_rc_clk_i <= 1'b1;
        cyc(3);
        chk("pin_hi", slow_osc_out_pin_o, 1'b1);
        @(posedge clk_sys_i);
        pm_slow_out_en_i <= 1'b0;
        cyc(3);
        chk("pin_pm_off", slow_osc_out_pin_o, 1'b0);
        chk("run_pm_off", slow_rc_osc_run_o, 1'b0);
        @(posedge clk_sys_i);
        pm_slow_out_en_i   <= 1'b1;
        pin_func_default_i <= 1'b0;
        cyc(3);
        chk("pin_func", slow_osc_out_pin_o, 1'b0);
        @(posedge clk_sys_i);
        pin_func_default_i <= 1'b1;
        sm_sampling_req_i  <= 1'b1;
        cyc(3);
        chk("sample_on", slow_rc_osc_en_o, 1'b1);
        pwr(OFS_SLOW_OSC_CFG, 32'h1);
        pwr(OFS_SLOW_OSC_CFG, 32'h0);
        cyc(1);
        chk("sample_hold", slow_rc_osc_en_o, 1'b1);
        @(posedge clk_sys_i);
        sm_sampling_req_i <= 1'b0;
        cyc(2);
        chk("sample_end", slow_rc_osc_en_o, 1'b0);
        pwr(OFS_SLOW_OSC_CFG, 32'h1);
        cyc(1);
        chk("slow_bit", slow_rc_osc_en_o, 1'b1);
    endtask : t_slow

    task automatic t_gclk();
        int p;
        wr(OFS_GEN_CLK_BASE, gc(3'h0, 8'h01, 1'b1, 1'b0));
        wr(OFS_GEN_CLK_BASE, gc(3'h0, 8'h01, 1'b1, 1'b1));
        wr(OFS_GEN_CLK_BASE + 12'h8, gc(3'h1, 8'h00, 1'b0, 1'b1));
        period(0, p);
        chk("div_period", p, 8);
        period(2, p);
        chk("src1_period", p, 4);
        chk("gclk1_idle", gclk_o[1], 1'b0);
        @(posedge clk_sys_i);
        sleep_pb_off_i <= 1'b1;
        cyc(10);
        chk("sleep_stop", gclk_o[0], 1'b0);
        @(posedge clk_sys_i);
        sleep_pb_off_i <= 1'b0;
        period(0, p);
        chk("wake", p, 8);
        wr(OFS_GEN_CLK_BASE + 12'hC, gc(3'h0, 8'hFF, 1'b1, 1'b0));
        wr(OFS_GEN_CLK_BASE + 12'hC, gc(3'h0, 8'hFF, 1'b1, 1'b1));
        period(3, p);
        chk("div_max", p, 1024);
        wr(OFS_GEN_CLK_BASE + 12'hC, gc(3'h0, 8'hFF, 1'b1, 1'b0));
        rd(OFS_GEN_CLK_BASE + 12'hC);
        chk("cen_drain", rd_q[0], 1'b1);
        chk("gclk_held", gclk_o[3], 1'b1);
        for (int i = 0; i < 400 && rd_q[0] !== 1'b0; i++) rd(OFS_GEN_CLK_BASE + 12'hC);
        chk("cen_off", rd_q[0], 1'b0);
        cyc(20);
        chk("gclk_off", gclk_o[3], 1'b0);
    endtask : t_gclk

    task automatic t_irq();
        logic [31:0] b;
        wr(OFS_IRQ_CLEAR, 32'hFFFFFFFF);
        for (int i = 0; i < 32; i++) begin
            if (EXT_FLAG_MASK[i]) begin
                b = 32'h1 << i;
                wr(OFS_IRQ_ENABLE_SET, b);
                wr(OFS_IRQ_ENABLE_SET, 32'h0);
                rd(OFS_IRQ_MASK);
                chk("mask_set", rd_q, b);
                @(posedge clk_sys_i);
                pwr_clk_flags_i <= b;
                cyc(2);
                chk("irq_on", irq_o, 1'b1);
                @(posedge clk_sys_i);
                pwr_clk_flags_i <= 32'h0;
                cyc(2);
                chk("irq_sticky", irq_o, 1'b1);
                rd(OFS_IRQ_STATUS);
                chk("status_bit", rd_q, b);
                wr(OFS_IRQ_DISABLE_SET, 32'h0);
                cyc(2);
                chk("irq_kept", irq_o, 1'b1);
                wr(OFS_IRQ_DISABLE_SET, b);
                cyc(2);
                chk("irq_masked", irq_o, 1'b0);
                wr(OFS_IRQ_CLEAR, b);
                rd(OFS_IRQ_STATUS);
                chk("status_clr", rd_q, 32'h0);
            end
        end
        wr(OFS_IRQ_ENABLE_SET, 32'h3);
        @(posedge clk_sys_i);
        pwr_clk_flags_i <= 32'h3;
        wr(OFS_IRQ_CLEAR, 32'h1);
        cyc(2);
        chk("irq_one_left", irq_o, 1'b1);
        wr(OFS_IRQ_CLEAR, 32'h2);
        cyc(2);
        chk("irq_all_clr", irq_o, 1'b0);
    endtask : t_irq

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        {rstn_i, por_rstn_i, sm_sampling_req_i, slow_rc_clk_i, sleep_pb_off_i} = '0;
        {pm_slow_out_en_i, pin_func_default_i} = 2'b11;
        pwr_clk_flags_i = 32'h0;
        gclk_src_i = '0;
        src_cnt = 2'h0;
        err_count = 0;
        n_tests = 0;
        cyc_cnt = 0;
        repeat (10) @(posedge clk_sys_i);
        rstn_i     <= 1'b1;
        por_rstn_i <= 1'b1;
        t_reset();
        t_fast();
        t_retain();
        t_slow();
        t_gclk();
        t_irq();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
